// file: dv/iord_chk.sv
// Concurrent checks on the ports of the I/O register space decoder.
`timescale 1ns/100ps
`default_nettype none

module iord_chk (
  // Clock and reset
  input wire logic                        mclk,
  input wire logic                        rstn,
  // Core access port
  input wire logic                        acc_valid,
  input wire iord_pkg::iord_kind_e        acc_kind,
  input wire logic [iord_pkg::ADDR_W-1:0] acc_addr,
  input wire logic [iord_pkg::DATA_W-1:0] acc_wdata,
  // Answers and storage
  input wire logic                        rd_valid,
  input wire logic                        acc_err,
  input wire logic                        ext_wr,
  input wire logic [iord_pkg::DATA_W-1:0] ext_addr,
  input wire iord_pkg::iord_regs_t        hw_set,
  input wire iord_pkg::iord_regs_t        io_regs
);
  import iord_pkg::*;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);

  a_bit_range_err: assert property (acc_valid && acc_kind inside {KIND_BIT_SET, KIND_BIT_CLR, KIND_SKIP_SET,
    KIND_SKIP_CLR} && acc_addr > BIT_LAST |=> acc_err && !rd_valid) else $error("bit access not refused");
  a_io_range_err: assert property (acc_valid && acc_kind inside {KIND_IO_RD, KIND_IO_WR} && acc_addr > IO_LAST
    |=> acc_err && !ext_wr) else $error("io access above range not refused");
  a_io_read_ok: assert property (acc_valid && acc_kind == KIND_IO_RD && acc_addr <= IO_LAST
    |=> rd_valid && !acc_err) else $error("io read not answered");
  a_ds_range_err: assert property (acc_valid && acc_kind inside {KIND_DS_RD, KIND_DS_WR}
    && (acc_addr < DS_IO_OFS || acc_addr > EXT_LAST) |=> acc_err && !ext_wr) else $error("data access not refused");
  a_ds_alias_wr: assert property (acc_valid && acc_kind == KIND_DS_WR && acc_addr == 16'h004A
    && hw_set[A_GP1] == 8'h00 |=> io_regs[A_GP1] == $past(acc_wdata)) else $error("data store missed alias");
  a_ext_store_fwd: assert property (acc_valid && acc_kind == KIND_DS_WR && acc_addr >= EXT_FIRST
    && acc_addr <= EXT_LAST |=> ext_wr && ext_addr == $past(acc_addr[7:0])) else $error("extended store lost");
  a_ext_store_cause: assert property (ext_wr |-> $past(acc_valid) && $past(acc_kind) == KIND_DS_WR)
    else $error("extended store without data store");
  a_flag_w1c: assert property (acc_valid && acc_kind == KIND_IO_WR && acc_addr == 16'h0015
    && hw_set[A_TIMER0_FLAGS] == 8'h00 |=> io_regs[A_TIMER0_FLAGS]
    == ($past(io_regs[A_TIMER0_FLAGS]) & ~$past(acc_wdata))) else $error("flag write-one-clear wrong");
  a_bit_rmw_flags: assert property (acc_valid && acc_kind == KIND_BIT_SET && acc_addr == 16'h0015
    && hw_set[A_TIMER0_FLAGS] == 8'h00 |=> io_regs[A_TIMER0_FLAGS] == 8'h00) else $error("bit set kept a flag");
  a_reserved_zero: assert property ((io_regs[A_EXT_IRQ_MASK] & 8'hF8) == 8'h00
    && io_regs[6'h0C] == 8'h00) else $error("reserved storage not zero");

  c_ext_store: cover property (ext_wr);
  c_refusal: cover property (acc_err);
  c_flag_clear: cover property (acc_valid && acc_kind == KIND_BIT_SET && acc_addr == 16'h0015);
endmodule : iord_chk

bind iord_top iord_chk u_chk (.mclk, .rstn, .acc_valid, .acc_kind, .acc_addr, .acc_wdata,
  .rd_valid, .acc_err, .ext_wr, .ext_addr, .hw_set, .io_regs);

`default_nettype wire

// file: dv/iord_ext_model.sv
// Behavioural model of the extended I/O area beyond the decoder.
`timescale 1ns/100ps
`default_nettype none

module iord_ext_model (
  // Clock
  input  wire logic        mclk,
  // Decoder side
  input  wire logic [15:0] acc_addr,
  input  wire logic        ext_wr,
  input  wire logic [7:0]  ext_addr,
  input  wire logic [7:0]  ext_wdata,
  output logic      [7:0]  ext_rdata
);
  logic [7:0] mem [256];

  // Stores arrive as one-cycle pulses from the decoder.
  always_ff @(posedge mclk) begin
    if (ext_wr) begin
      mem[ext_addr] <= ext_wdata;
    end
  end

  // Read data must follow the address in the cycle of the request.
  assign ext_rdata = mem[acc_addr[7:0]];
endmodule : iord_ext_model

`default_nettype wire

// file: dv/tb_top.sv
// Self-checking testbench of the I/O register space decoder.
`timescale 1ns/100ps
`default_nettype none

module tb_top;
  import iord_pkg::*;

  logic            mclk      = 1'b0;
  logic            rstn      = 1'b0;
  logic            acc_valid = 1'b0;
  iord_kind_e      acc_kind  = KIND_IO_RD;
  logic [15:0]     acc_addr  = 16'h0000;
  logic [2:0]      acc_bit   = 3'h0;
  logic [7:0]      acc_wdata = 8'h00;
  logic [3:0][7:0] pins      = '0;
  iord_regs_t      hw_set    = '0;
  iord_regs_t      hw_stat   = '0;
  iord_regs_t      io_regs;
  logic [7:0]      ext_rdata, rd_data, ext_addr, ext_wdata, got_rd;
  logic            rd_valid, skip, acc_err, ext_wr, got_rv, got_sk, got_er, got_ew;
  int              error_cnt   = 0;
  int              comparisons = 0;
  int              cycles      = 0;

  always #25 mclk = ~mclk;

  iord_top dut (.mclk(mclk), .rstn(rstn), .acc_valid(acc_valid), .acc_kind(acc_kind), .acc_addr(acc_addr),
    .acc_bit(acc_bit), .acc_wdata(acc_wdata), .rd_valid(rd_valid), .rd_data(rd_data), .skip(skip),
    .acc_err(acc_err), .ext_rdata(ext_rdata), .ext_wr(ext_wr), .ext_addr(ext_addr), .ext_wdata(ext_wdata),
    .port_a_pins(pins[0]), .port_b_pins(pins[1]), .port_c_pins(pins[2]), .port_d_pins(pins[3]),
    .hw_set(hw_set), .hw_stat(hw_stat), .io_regs(io_regs));

  iord_ext_model u_ext (.mclk(mclk), .acc_addr(acc_addr), .ext_wr(ext_wr), .ext_addr(ext_addr),
    .ext_wdata(ext_wdata), .ext_rdata(ext_rdata));

  // ---------------------------------------------------------------------------
  // Access tasks
  // ---------------------------------------------------------------------------
  task automatic wrap_up;
    $display("Comparisons %0d, mismatches %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : wrap_up

  task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
    comparisons++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] %s at %h expected %h seen %h", name, acc_addr, exp, got);
    end
  endtask : chk

  // Software writes keep reserved bits zero and avoid reserved addresses.
  task automatic acc(input iord_kind_e k, input logic [15:0] a, input logic [2:0] b, input logic [7:0] w);
    @(posedge mclk);
    acc_valid <= 1'b1;
    acc_kind  <= k;
    acc_addr  <= a;
    acc_bit   <= b;
    acc_wdata <= w;
    @(posedge mclk);
    acc_valid <= 1'b0;
    #1;
    got_rv = rd_valid;
    got_sk = skip;
    got_er = acc_err;
    got_ew = ext_wr;
    got_rd = rd_data;
  endtask : acc

  task automatic rd(input iord_kind_e k, input logic [15:0] a, input logic [7:0] exp);
    acc(k, a, 3'h0, 8'h00);
    chk("read valid", 8'h01, {7'h00, got_rv});
    chk("read data", exp, got_rd);
  endtask : rd

  task automatic refused(input iord_kind_e k, input logic [15:0] a);
    acc(k, a, 3'h0, 8'h00);
    chk("refusal", 8'h01, {7'h00, got_er});
    chk("no store", 8'h00, {7'h00, got_ew});
  endtask : refused

  task automatic hw_pulse(input logic [5:0] a, input logic [7:0] v);
    @(posedge mclk);
    hw_set[a] <= v;
    @(posedge mclk);
    hw_set[a] <= 8'h00;
  endtask : hw_pulse

  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (cycles == 1000) begin
      error_cnt++;
      wrap_up();
    end
  end

  // ---------------------------------------------------------------------------
  // Test sequence
  // ---------------------------------------------------------------------------
  initial begin
    repeat (2) @(posedge mclk);
    rstn <= 1'b1;
    pins <= {8'h96, 8'h3C, 8'h81, 8'h5A};
    acc(KIND_IO_WR, 16'h0001, 3'h0, 8'hA5);
    rd(KIND_IO_RD, 16'h0001, 8'hA5);
    rd(KIND_DS_RD, 16'h0021, 8'hA5);
    acc(KIND_DS_WR, 16'h004A, 3'h0, 8'h3C);
    rd(KIND_IO_RD, 16'h002A, 8'h3C);
    chk("gp1 stored", 8'h3C, io_regs[A_GP1]);
    for (int i = 0; i < 4; i++) begin
      rd(KIND_IO_RD, 16'(3 * i), pins[i]);
    end
    rd(KIND_IO_RD, 16'h000C, 8'h00);
    hw_pulse(A_EXT_IRQ_MASK, 8'hFF);
    rd(KIND_DS_RD, 16'h003D, 8'h07);
    acc(KIND_SKIP_SET, 16'h001D, 3'h1, 8'h00);
    chk("skip if set", 8'h01, {7'h00, got_sk});
    acc(KIND_SKIP_CLR, 16'h001D, 3'h1, 8'h00);
    chk("skip if clear", 8'h00, {7'h00, got_sk});
    acc(KIND_SKIP_CLR, 16'h001D, 3'h3, 8'h00);
    chk("reserved bit test", 8'h01, {7'h00, got_sk});
    acc(KIND_BIT_SET, 16'h001F, 3'h5, 8'h00);
    rd(KIND_IO_RD, 16'h001F, 8'h20);
    acc(KIND_BIT_CLR, 16'h001F, 3'h5, 8'h00);
    rd(KIND_IO_RD, 16'h001F, 8'h00);
    hw_pulse(A_TIMER0_FLAGS, 8'hFF);
    rd(KIND_IO_RD, 16'h0015, 8'h07);
    acc(KIND_IO_WR, 16'h0015, 3'h0, 8'h02);
    rd(KIND_IO_RD, 16'h0015, 8'h05);
    acc(KIND_IO_WR, 16'h0015, 3'h0, 8'h00);
    rd(KIND_IO_RD, 16'h0015, 8'h05);
    acc(KIND_BIT_SET, 16'h0015, 3'h1, 8'h00);
    rd(KIND_IO_RD, 16'h0015, 8'h00);
    for (int k = 4; k < 8; k++) begin
      refused(iord_kind_e'(3'(k)), 16'h0020);
    end
    refused(KIND_IO_RD, 16'h0040);
    refused(KIND_IO_WR, 16'h0060);
    refused(KIND_DS_RD, 16'h001F);
    refused(KIND_DS_WR, 16'h0100);
    // Live status bits read through while the stored bit keeps the written value.
    @(posedge mclk);
    hw_stat[A_SER_STATUS] <= 8'hFF;
    acc(KIND_IO_WR, 16'h002D, 3'h0, 8'h01);
    rd(KIND_IO_RD, 16'h002D, 8'hC1);
    acc(KIND_DS_WR, 16'h0070, 3'h0, 8'h5A);
    chk("ext store", 8'h01, {7'h00, got_ew});
    chk("ext addr", 8'h70, ext_addr);
    chk("ext data", 8'h5A, ext_wdata);
    rd(KIND_DS_RD, 16'h0070, 8'h5A);
    acc(KIND_DS_WR, 16'h00FF, 3'h0, 8'hC3);
    rd(KIND_DS_RD, 16'h00FF, 8'hC3);
    wrap_up();
  end
endmodule : tb_top

`default_nettype wire

// file: hdl/iord_pkg.sv
// Package with the constants, masks and types of the I/O register space decoder.
package iord_pkg;

  // ----------------------------------------------------------------------------
  // Sizes and address windows
  // ----------------------------------------------------------------------------
  localparam int unsigned IO_SIZE   = 64;
  localparam int unsigned DATA_W    = 8;
  localparam int unsigned ADDR_W    = 16;
  localparam int unsigned IO_AW     = 6;
  localparam int unsigned NUM_PORTS = 4;

  localparam logic [15:0] IO_LAST     = 16'h003F;
  localparam logic [15:0] BIT_LAST    = 16'h001F;
  localparam logic [15:0] DS_IO_OFS   = 16'h0020;
  localparam logic [15:0] EXT_FIRST   = 16'h0060;
  localparam logic [15:0] EXT_LAST    = 16'h00FF;
  localparam logic [7:0]  REG_RST_VAL = 8'h00;

  // ----------------------------------------------------------------------------
  // Register offsets in I/O space
  // ----------------------------------------------------------------------------
  localparam logic [5:0] A_PORT_A_PINS  = 6'h00;
  localparam logic [5:0] A_PORT_A_DIR   = 6'h01;
  localparam logic [5:0] A_PORT_A_OUT   = 6'h02;
  localparam logic [5:0] A_PORT_B_PINS  = 6'h03;
  localparam logic [5:0] A_PORT_B_DIR   = 6'h04;
  localparam logic [5:0] A_PORT_B_OUT   = 6'h05;
  localparam logic [5:0] A_PORT_C_PINS  = 6'h06;
  localparam logic [5:0] A_PORT_C_DIR   = 6'h07;
  localparam logic [5:0] A_PORT_C_OUT   = 6'h08;
  localparam logic [5:0] A_PORT_D_PINS  = 6'h09;
  localparam logic [5:0] A_PORT_D_DIR   = 6'h0A;
  localparam logic [5:0] A_PORT_D_OUT   = 6'h0B;
  localparam logic [5:0] A_TIMER0_FLAGS = 6'h15;
  localparam logic [5:0] A_TIMER1_FLAGS = 6'h16;
  localparam logic [5:0] A_TIMER2_FLAGS = 6'h17;
  localparam logic [5:0] A_TIMER3_FLAGS = 6'h18;
  localparam logic [5:0] A_PIN_CHG_FLAG = 6'h1B;
  localparam logic [5:0] A_EXT_IRQ_FLAG = 6'h1C;
  localparam logic [5:0] A_EXT_IRQ_MASK = 6'h1D;
  localparam logic [5:0] A_GP0          = 6'h1E;
  localparam logic [5:0] A_NVM_CTRL     = 6'h1F;
  localparam logic [5:0] A_NVM_DATA     = 6'h20;
  localparam logic [5:0] A_NVM_ADDR_LO  = 6'h21;
  localparam logic [5:0] A_NVM_ADDR_HI  = 6'h22;
  localparam logic [5:0] A_PRESC_SYNC   = 6'h23;
  localparam logic [5:0] A_TMR0_CTRL_A  = 6'h24;
  localparam logic [5:0] A_TMR0_CTRL_B  = 6'h25;
  localparam logic [5:0] A_TMR0_COUNT   = 6'h26;
  localparam logic [5:0] A_TMR0_CMP_A   = 6'h27;
  localparam logic [5:0] A_TMR0_CMP_B   = 6'h28;
  localparam logic [5:0] A_GP1          = 6'h2A;
  localparam logic [5:0] A_GP2          = 6'h2B;
  localparam logic [5:0] A_SER_CTRL     = 6'h2C;
  localparam logic [5:0] A_SER_STATUS   = 6'h2D;
  localparam logic [5:0] A_SER_DATA     = 6'h2E;
  localparam logic [5:0] A_CMP_CTRL     = 6'h30;
  localparam logic [5:0] A_DEBUG_CHAN   = 6'h31;
  localparam logic [5:0] A_SLEEP_CTRL   = 6'h33;
  localparam logic [5:0] A_RESET_CAUSE  = 6'h34;
  localparam logic [5:0] A_CORE_CTRL    = 6'h35;
  localparam logic [5:0] A_SELF_PROG    = 6'h37;

  // ----------------------------------------------------------------------------
  // Access kinds issued by the core
  // ----------------------------------------------------------------------------
  typedef enum logic [2:0] {
    KIND_IO_RD     = 3'b000,
    KIND_IO_WR     = 3'b001,
    KIND_DS_RD     = 3'b010,
    KIND_DS_WR     = 3'b011,
    KIND_BIT_SET   = 3'b100,
    KIND_BIT_CLR   = 3'b101,
    KIND_SKIP_SET  = 3'b110,
    KIND_SKIP_CLR  = 3'b111
  } iord_kind_e;

  typedef logic [IO_SIZE-1:0][DATA_W-1:0]   iord_regs_t;
  typedef logic [NUM_PORTS-1:0][DATA_W-1:0] iord_pins_t;

  typedef struct packed {
    iord_regs_t        regs;
    iord_pins_t        pin_meta;
    iord_pins_t        pin_sync;
    logic              rd_valid;
    logic [DATA_W-1:0] rd_data;
    logic              skip;
    logic              err;
    logic              ext_wr;
    logic [DATA_W-1:0] ext_addr;
    logic [DATA_W-1:0] ext_wdata;
  } iord_state_s;

  // ----------------------------------------------------------------------------
  // Per-register bit masks
  // ----------------------------------------------------------------------------
  // Bits that software writes and reads back as stored.
  function automatic logic [7:0] iord_wmask(input logic [5:0] a);
    logic [7:0] m;
    m = 8'h00;
    unique case (a)
      A_PORT_A_DIR, A_PORT_A_OUT, A_PORT_B_DIR, A_PORT_B_OUT,
      A_PORT_C_DIR, A_PORT_C_OUT, A_PORT_D_DIR, A_PORT_D_OUT: m = 8'hFF;
      A_EXT_IRQ_MASK:                                         m = 8'h07;
      A_GP0, A_GP1, A_GP2, A_NVM_DATA, A_NVM_ADDR_LO:         m = 8'hFF;
      A_NVM_CTRL:                                             m = 8'h3F;
      A_NVM_ADDR_HI:                                          m = 8'h0F;
      A_PRESC_SYNC:                                           m = 8'h83;
      A_TMR0_CTRL_A:                                          m = 8'hF3;
      A_TMR0_CTRL_B:                                          m = 8'hCF;
      A_TMR0_COUNT, A_TMR0_CMP_A, A_TMR0_CMP_B:               m = 8'hFF;
      A_SER_CTRL, A_SER_DATA, A_DEBUG_CHAN:                   m = 8'hFF;
      A_SER_STATUS:                                           m = 8'h01;
      A_CMP_CTRL:                                             m = 8'hCF;
      A_SLEEP_CTRL:                                           m = 8'h0F;
      A_RESET_CAUSE:                                          m = 8'h1F;
      A_CORE_CTRL:                                            m = 8'hF3;
      A_SELF_PROG:                                            m = 8'hBF;
      default:                                                m = 8'h00;
    endcase
    return m;
  endfunction : iord_wmask

  // Flag bits that hardware sets and a written one clears.
  function automatic logic [7:0] iord_cmask(input logic [5:0] a);
    logic [7:0] m;
    m = 8'h00;
    unique case (a)
      A_TIMER0_FLAGS, A_TIMER2_FLAGS, A_EXT_IRQ_FLAG: m = 8'h07;
      A_TIMER1_FLAGS, A_TIMER3_FLAGS:                 m = 8'h27;
      A_PIN_CHG_FLAG:                                 m = 8'h0F;
      A_CMP_CTRL:                                     m = 8'h10;
      default:                                        m = 8'h00;
    endcase
    return m;
  endfunction : iord_cmask

  // Bits that read the live status of the peripheral and ignore writes.
  function automatic logic [7:0] iord_smask(input logic [5:0] a);
    logic [7:0] m;
    m = 8'h00;
    unique case (a)
      A_SER_STATUS: m = 8'hC0;
      A_CMP_CTRL:   m = 8'h20;
      A_SELF_PROG:  m = 8'h40;
      default:      m = 8'h00;
    endcase
    return m;
  endfunction : iord_smask

endpackage : iord_pkg

// file: hdl/iord_top.sv
// I/O register space decoder: access decode, bit access, flag handling and register storage.
//
// Function
// RULE1 - Bit set, bit clear and bit test accesses work only on I/O locations 0x00 to 0x1F and are refused above.
// RULE2 - Status flags are cleared by writing one to their position, and writing zero leaves them unchanged.
// RULE3 - Bit set and bit clear rewrite the whole register, so any flag read as set is written back as one and cleared.
// RULE4 - Dedicated I/O reads and writes address the register space with I/O addresses 0x00 to 0x3F.
// RULE5 - Data-space loads and stores reach the same registers at their I/O address plus 0x20.
// RULE6 - The extended area from data address 0x60 upward is reached only by loads and stores.
// RULE7 - Software should write zero into reserved bit positions.
// RULE8 - Software never writes reserved I/O addresses.
// RULE9 - Reserved addresses and reserved bits read as zero and ignore writes.
`timescale 1ns/100ps
`default_nettype none

module iord_top (
  // Clock and reset
  input  wire logic                            mclk,
  input  wire logic                            rstn,
  // Core access port
  input  wire logic                            acc_valid,
  input  wire iord_pkg::iord_kind_e            acc_kind,
  input  wire logic [iord_pkg::ADDR_W-1:0]     acc_addr,
  input  wire logic [2:0]                      acc_bit,
  input  wire logic [iord_pkg::DATA_W-1:0]     acc_wdata,
  // Core answer
  output logic                                 rd_valid,
  output logic [iord_pkg::DATA_W-1:0]          rd_data,
  output logic                                 skip,
  output logic                                 acc_err,
  // Extended I/O area
  input  wire logic [iord_pkg::DATA_W-1:0]     ext_rdata,
  output logic                                 ext_wr,
  output logic [iord_pkg::DATA_W-1:0]          ext_addr,
  output logic [iord_pkg::DATA_W-1:0]          ext_wdata,
  // Port pins
  input  wire logic [iord_pkg::DATA_W-1:0]     port_a_pins,
  input  wire logic [iord_pkg::DATA_W-1:0]     port_b_pins,
  input  wire logic [iord_pkg::DATA_W-1:0]     port_c_pins,
  input  wire logic [iord_pkg::DATA_W-1:0]     port_d_pins,
  // Peripheral side
  input  wire iord_pkg::iord_regs_t            hw_set,
  input  wire iord_pkg::iord_regs_t            hw_stat,
  output iord_pkg::iord_regs_t                 io_regs
);
  import iord_pkg::*;

  // ----------------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------------
  iord_state_s       st_ff;
  iord_state_s       nxt_st;

  logic              io_hit;
  logic [IO_AW-1:0]  io_idx;
  logic              ext_hit;
  logic              wr_en;
  logic [DATA_W-1:0] wr_data;
  logic [DATA_W-1:0] cur;
  logic [DATA_W-1:0] bit_sel;
  logic [DATA_W-1:0] tmp;
  logic [DATA_W-1:0] wm;
  logic [DATA_W-1:0] cm;

  // Pin register index, or NUM_PORTS when the address is not a pin register.
  function automatic logic [2:0] pin_index(input logic [IO_AW-1:0] a);
    logic [2:0] p;
    p = 3'(NUM_PORTS);
    unique case (a)
      A_PORT_A_PINS: p = 3'd0;
      A_PORT_B_PINS: p = 3'd1;
      A_PORT_C_PINS: p = 3'd2;
      A_PORT_D_PINS: p = 3'd3;
      default:       p = 3'(NUM_PORTS);
    endcase
    return p;
  endfunction : pin_index

  // Read value of one location; pin registers return the synchronised pins, elsewhere bits outside every mask read as zero.
  function automatic logic [DATA_W-1:0] read_val(input logic [IO_AW-1:0] a,
                                                 input logic [DATA_W-1:0] stored,
                                                 input logic [DATA_W-1:0] live,
                                                 input iord_pins_t pins);
    logic [DATA_W-1:0] v;
    logic [2:0]        p;
    p = pin_index(a);
    v = (stored & (iord_wmask(a) | iord_cmask(a))) | (live & iord_smask(a)); // [RULE9]
    if (p < 3'(NUM_PORTS)) begin
      v = pins[p[1:0]];
    end
    return v;
  endfunction : read_val

  // ----------------------------------------------------------------------------
  // Access decode
  // ----------------------------------------------------------------------------
  always_comb begin
    nxt_st          = st_ff;
    nxt_st.rd_valid = 1'b0;
    nxt_st.skip     = 1'b0;
    nxt_st.err      = 1'b0;
    nxt_st.ext_wr   = 1'b0;
    nxt_st.pin_meta = {port_d_pins, port_c_pins, port_b_pins, port_a_pins};
    nxt_st.pin_sync = st_ff.pin_meta;
    io_hit          = 1'b0;
    io_idx          = '0;
    ext_hit         = 1'b0;
    wr_en           = 1'b0;
    wr_data         = '0;
    tmp             = '0;
    wm              = '0;
    cm              = '0;
    bit_sel         = DATA_W'(1) << acc_bit;

    if (acc_valid) begin
      unique case (acc_kind)
        KIND_IO_RD, KIND_IO_WR: begin
          if (acc_addr <= IO_LAST) begin // [RULE4]
            io_hit = 1'b1;
            io_idx = acc_addr[IO_AW-1:0];
          end else begin
            nxt_st.err = 1'b1;
          end
        end
        KIND_DS_RD, KIND_DS_WR: begin
          if (acc_addr >= DS_IO_OFS && acc_addr < EXT_FIRST) begin
            io_hit = 1'b1;
            io_idx = IO_AW'(acc_addr - DS_IO_OFS); // [RULE5]
          end else if (acc_addr >= EXT_FIRST && acc_addr <= EXT_LAST) begin
            ext_hit = 1'b1; // [RULE6]
          end else begin
            nxt_st.err = 1'b1;
          end
        end
        default: begin
          if (acc_addr <= BIT_LAST) begin // [RULE1]
            io_hit = 1'b1;
            io_idx = acc_addr[IO_AW-1:0];
          end else begin
            nxt_st.err = 1'b1;
          end
        end
      endcase
    end

    cur = read_val(io_idx, st_ff.regs[io_idx], hw_stat[io_idx], st_ff.pin_sync);

    if (io_hit) begin
      unique case (acc_kind)
        KIND_IO_RD, KIND_DS_RD: begin
          nxt_st.rd_valid = 1'b1;
          nxt_st.rd_data  = cur;
        end
        KIND_IO_WR, KIND_DS_WR: begin
          wr_en   = 1'b1;
          wr_data = acc_wdata;
        end
        KIND_BIT_SET: begin
          wr_en   = 1'b1;
          wr_data = cur | bit_sel; // [RULE3]
        end
        KIND_BIT_CLR: begin
          wr_en   = 1'b1;
          wr_data = cur & ~bit_sel; // [RULE3]
        end
        KIND_SKIP_SET: begin
          nxt_st.rd_valid = 1'b1;
          nxt_st.rd_data  = cur;
          nxt_st.skip     = |(cur & bit_sel); // [RULE1]
        end
        KIND_SKIP_CLR: begin
          nxt_st.rd_valid = 1'b1;
          nxt_st.rd_data  = cur;
          nxt_st.skip     = ~|(cur & bit_sel); // [RULE1]
        end
      endcase
    end

    // The extended area is decoded outside; its read data arrives in the same cycle.
    if (ext_hit) begin
      if (acc_kind == KIND_DS_WR) begin
        nxt_st.ext_wr    = 1'b1;
        nxt_st.ext_addr  = acc_addr[DATA_W-1:0];
        nxt_st.ext_wdata = acc_wdata;
      end else begin
        nxt_st.rd_valid = 1'b1;
        nxt_st.rd_data  = ext_rdata;
      end
    end

    // --------------------------------------------------------------------------
    // Register update: stored bits, write-one-to-clear flags, hardware set wins
    // --------------------------------------------------------------------------
    for (int i = 0; i < IO_SIZE; i++) begin
      wm  = iord_wmask(IO_AW'(i));
      cm  = iord_cmask(IO_AW'(i));
      tmp = st_ff.regs[i];
      if (wr_en && io_idx == IO_AW'(i)) begin
        tmp = (tmp & ~wm) | (wr_data & wm); // [RULE9]
        tmp = tmp & ~(wr_data & cm); // [RULE2]
      end
      tmp            = tmp | (hw_set[i] & (wm | cm));
      nxt_st.regs[i] = tmp & (wm | cm); // [RULE9]
    end
  end

  // ----------------------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      st_ff           <= '0;
      st_ff.regs      <= {IO_SIZE{REG_RST_VAL}};
    end else begin
      st_ff <= nxt_st;
    end
  end

  // ----------------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------------
  assign rd_valid  = st_ff.rd_valid;
  assign rd_data   = st_ff.rd_data;
  assign skip      = st_ff.skip;
  assign acc_err   = st_ff.err;
  assign ext_wr    = st_ff.ext_wr;
  assign ext_addr  = st_ff.ext_addr;
  assign ext_wdata = st_ff.ext_wdata;
  assign io_regs   = st_ff.regs;

endmodule : iord_top

`default_nettype wire
